// >>> pcb_pkg.sv
package pcb_pkg;

    localparam int NUM_REGS = 7;

    localparam logic [7:0] OFS_C_FILTER = 8'h05;
    localparam logic [7:0] OFS_C_PUMP = 8'h06;
    localparam logic [7:0] OFS_A_CTRL = 8'h07;
    localparam logic [7:0] OFS_A_REF = 8'h08;
    localparam logic [7:0] OFS_A_FB_LOW = 8'h09;
    localparam logic [7:0] OFS_A_FILTER = 8'h0A;
    localparam logic [7:0] OFS_A_PUMP = 8'h0B;

    localparam int IDX_C_FILTER = 0;
    localparam int IDX_C_PUMP = 1;
    localparam int IDX_A_CTRL = 2;
    localparam int IDX_A_REF = 3;
    localparam int IDX_A_FB_LOW = 4;
    localparam int IDX_A_FILTER = 5;
    localparam int IDX_A_PUMP = 6;

    localparam logic [7:0] RST_C_FILTER = 8'h11;
    localparam logic [7:0] RST_C_PUMP = 8'h6C;
    localparam logic [7:0] RST_A_CTRL = 8'h23;
    localparam logic [7:0] RST_A_REF = 8'h19;
    localparam logic [7:0] RST_A_FB_LOW = 8'h58;
    localparam logic [7:0] RST_A_FILTER = 8'hB2;
    localparam logic [7:0] RST_A_PUMP = 8'h06;
    localparam logic [6:0][7:0] RST_ALL = {RST_A_PUMP, RST_A_FILTER,
        RST_A_FB_LOW, RST_A_REF, RST_A_CTRL, RST_C_PUMP, RST_C_FILTER};

    // Field positions (low bit) and widths
    localparam int RES_TOP_POS = 4;
    localparam int RES_TOP_W = 4;
    localparam int RES_ONLY_POS = 3;
    localparam int FB_HIGH_POS = 0;
    localparam int FB_HIGH_W = 3;
    localparam int DIV3_ORIGIN_POS = 7;
    localparam int C_PUMP_WT_POS = 3;
    localparam int C_PUMP_WT_W = 4;
    localparam int C_PUMP_D24_POS = 2;
    localparam int C_PUMP_D3_POS = 1;
    localparam int C_BASE_SEL_POS = 0;
    localparam int A_DOUBLER_POS = 7;
    localparam int A_BASE_SEL_POS = 6;
    localparam int A_CH2_POS = 5;
    localparam int A_POLE_POS = 4;
    localparam int DIV5_POS = 0;
    localparam int DIV5_W = 4;
    localparam int A_BYP1_POS = 7;
    localparam int A_BYP2_POS = 6;
    localparam int A_REF_POS = 0;
    localparam int A_REF_W = 6;
    localparam int A_PUMP_WT_POS = 2;
    localparam int A_PUMP_WT_W = 6;
    localparam int A_PUMP_D24_POS = 1;
    localparam int A_PUMP_D3_POS = 0;

    // Base currents in nA, resistances in units of 100 ohm
    localparam logic [13:0] C_BASE_NA = 14'h2710;
    localparam logic [13:0] A_BASE_NA = 14'h2A30;
    localparam logic [5:0] PUMP_DIV_LARGE = 6'h18;
    localparam logic [5:0] PUMP_DIV_SMALL = 6'h03;
    localparam logic [3:0][10:0] RES_TOP_UNITS = {11'h3E8, 11'h1F4,
        11'h0FA, 11'h07D};
    localparam logic [10:0] C_RES_ONLY_UNITS = 11'h03C;
    localparam logic [10:0] A_RES_ONLY_UNITS = 11'h00A;
    localparam logic [3:0][2:0] DIV5_HI = {3'h5, 3'h4, 3'h2, 3'h1};
    localparam logic [3:0][3:0] DIV5_LO = {4'hA, 4'h5, 4'h3, 4'h1};

    function automatic logic in_range(input logic [7:0] addr);
        return (addr >= OFS_C_FILTER) && (addr <= OFS_A_PUMP);
    endfunction : in_range

    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - OFS_C_FILTER;
        return diff[2:0];
    endfunction : reg_index

    function automatic logic [20:0] pump_current(input logic [13:0] base,
        input logic sel, input logic [5:0] weights, input logic d24,
        input logic d3);
        logic [26:0] prod;
        logic [5:0] div;
        prod = 27'(base) * 27'(weights);
        if (sel) begin
            prod = {prod[25:0], 1'b0};
        end
        div = (d24 ? PUMP_DIV_LARGE : 6'h00) + (d3 ? PUMP_DIV_SMALL : 6'h00);
        // No divisor enabled: pump treated as off
        if (div == 6'h00) begin
            return 21'h000000;
        end
        return 21'(prod / 27'(div));
    endfunction : pump_current

    function automatic logic [10:0] loop_res(input logic [3:0] top,
        input logic only, input logic [10:0] only_units);
        logic [10:0] sum;
        sum = 11'h000;
        for (int i = 0; i < 4; i++) begin
            if (top[i]) begin
                sum = sum + RES_TOP_UNITS[i];
            end
        end
        return only ? only_units : sum;
    endfunction : loop_res

    function automatic logic [5:0] div5_ratio(input logic [3:0] code);
        logic [6:0] prod;
        prod = 7'(DIV5_HI[code[3:2]]) * 7'(DIV5_LO[code[1:0]]);
        return prod[5:0];
    endfunction : div5_ratio

endpackage : pcb_pkg

// >>> pcb_stage.sv
`timescale 1ns/1ns
module pcb_stage (
    input wire logic sys_clk_in, // System clock
    input wire logic nrst_in, // Sync reset, active low
    input wire logic start_in, // Block transfer begins
    input wire logic [7:0] start_addr_in, // First register position
    input wire logic wr_valid_in, // Write data byte strobe
    input wire logic [7:0] wr_byte_in, // Write data byte
    input wire logic rd_req_in, // Read byte request
    input wire logic stop_in, // Stop condition strobe
    output logic [7:0] ptr_out, // Current register position
    output logic commit_out, // Commit pulse
    output logic [6:0] commit_mask_out, // Registers to commit
    output logic [6:0][7:0] commit_data_out // Bytes to commit
);
    import pcb_pkg::*;

    logic [6:0][7:0] held;
    logic [6:0] pend;
    logic [7:0] next_ptr;

    assign next_ptr = ptr_out + 8'h01;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ptr_out <= 8'h00;
        end else if (start_in) begin
            ptr_out <= start_addr_in;
        end else if (wr_valid_in || rd_req_in) begin
            ptr_out <= next_ptr; // [RULE_22]
        end
    end

    // Bytes are only held here until the stop arrives
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            held <= '0;
            pend <= 7'h00;
        end else if (stop_in) begin
            pend <= 7'h00;
        end else if (wr_valid_in && !start_in && in_range(ptr_out)) begin
            held[reg_index(ptr_out)] <= wr_byte_in; // [RULE_21]
            pend[reg_index(ptr_out)] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            commit_out <= 1'b0;
            commit_mask_out <= 7'h00;
            commit_data_out <= '0;
        end else begin
            commit_out <= stop_in && (pend != 7'h00); // [RULE_21]
            commit_mask_out <= stop_in ? pend : 7'h00;
            commit_data_out <= held;
        end
    end

    sequence byte_taken_s;
        (wr_valid_in || rd_req_in) && !start_in;
    endsequence

    sequence stop_pending_s;
        stop_in && (pend != 7'h00);
    endsequence

    ptr_ascends_a: assert property ( // [RULE_22]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        byte_taken_s |=> ptr_out == $past(next_ptr))
        else $error("position did not step up by one");

    start_loads_a: assert property ( // [RULE_22]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        start_in |=> ptr_out == $past(start_addr_in))
        else $error("start position not loaded");

    commit_at_stop_a: assert property ( // [RULE_21]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        stop_pending_s |=> commit_out && commit_mask_out == $past(pend)
            && commit_data_out == $past(held))
        else $error("held bytes not committed at stop");

    no_commit_early_a: assert property ( // [RULE_21]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        commit_out |-> $past(stop_in))
        else $error("commit without stop");

endmodule : pcb_stage

// >>> pcb_decode.sv
`timescale 1ns/1ns
module pcb_decode (
    input wire logic sys_clk_in, // System clock
    input wire logic nrst_in, // Sync reset, active low
    input wire logic [7:0] c_filter_in, // Third PLL filter byte
    input wire logic [7:0] c_pump_in, // Third PLL pump byte
    input wire logic [7:0] a_ctrl_in, // First PLL control byte
    input wire logic [7:0] a_filter_in, // First PLL filter byte
    input wire logic [7:0] a_pump_in, // First PLL pump byte
    output logic [5:0] div5_ratio_out, // Divider 5 ratio
    output logic [20:0] c_pump_na_out, // Third PLL pump, nA
    output logic [20:0] a_pump_na_out, // First PLL pump, nA
    output logic [10:0] c_res_out, // Third PLL filter, 100 ohm
    output logic [10:0] a_res_out // First PLL filter, 100 ohm
);
    import pcb_pkg::*;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            div5_ratio_out <= div5_ratio(RST_A_CTRL[DIV5_POS +: DIV5_W]);
        end else begin
            div5_ratio_out <=
                div5_ratio(a_ctrl_in[DIV5_POS +: DIV5_W]); // [RULE_20]
        end
    end

    // Third PLL has no x32 or x16 enable, so its top two weight bits are zero
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            c_pump_na_out <= pump_current(C_BASE_NA, RST_C_PUMP[C_BASE_SEL_POS],
                {2'b00, RST_C_PUMP[C_PUMP_WT_POS +: C_PUMP_WT_W]},
                RST_C_PUMP[C_PUMP_D24_POS], RST_C_PUMP[C_PUMP_D3_POS]);
            a_pump_na_out <= pump_current(A_BASE_NA, RST_A_CTRL[A_BASE_SEL_POS],
                RST_A_PUMP[A_PUMP_WT_POS +: A_PUMP_WT_W],
                RST_A_PUMP[A_PUMP_D24_POS], RST_A_PUMP[A_PUMP_D3_POS]);
        end else begin
            c_pump_na_out <= pump_current(C_BASE_NA, c_pump_in[C_BASE_SEL_POS],
                {2'b00, c_pump_in[C_PUMP_WT_POS +: C_PUMP_WT_W]},
                c_pump_in[C_PUMP_D24_POS],
                c_pump_in[C_PUMP_D3_POS]); // [RULE_07]
            a_pump_na_out <= pump_current(A_BASE_NA, a_ctrl_in[A_BASE_SEL_POS],
                a_pump_in[A_PUMP_WT_POS +: A_PUMP_WT_W],
                a_pump_in[A_PUMP_D24_POS],
                a_pump_in[A_PUMP_D3_POS]); // [RULE_07]
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            c_res_out <= loop_res(RST_C_FILTER[RES_TOP_POS +: RES_TOP_W],
                RST_C_FILTER[RES_ONLY_POS], C_RES_ONLY_UNITS);
            a_res_out <= loop_res(RST_A_FILTER[RES_TOP_POS +: RES_TOP_W],
                RST_A_FILTER[RES_ONLY_POS], A_RES_ONLY_UNITS);
        end else begin
            c_res_out <= loop_res(c_filter_in[RES_TOP_POS +: RES_TOP_W],
                c_filter_in[RES_ONLY_POS],
                C_RES_ONLY_UNITS); // [RULE_01] [RULE_02]
            a_res_out <= loop_res(a_filter_in[RES_TOP_POS +: RES_TOP_W],
                a_filter_in[RES_ONLY_POS],
                A_RES_ONLY_UNITS); // [RULE_16] [RULE_17]
        end
    end

    div5_top_a: assert property ( // [RULE_20]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        a_ctrl_in[DIV5_POS +: DIV5_W] == 4'hF |=> div5_ratio_out == 6'h32)
        else $error("divider 5 top code not 50");

    div5_span_a: assert property ( // [RULE_20]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        div5_ratio_out >= 6'h01 && div5_ratio_out <= 6'h32)
        else $error("divider 5 ratio out of span");

    c_res_only_a: assert property ( // [RULE_02]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        c_filter_in[RES_ONLY_POS] |=> c_res_out == 11'h03C)
        else $error("third PLL 6k not applied alone");

    a_res_sum_a: assert property ( // [RULE_16]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        a_filter_in[7:3] == 5'b11110 |=> a_res_out == 11'h753)
        else $error("first PLL resistor sum wrong");

    c_pump_calc_a: assert property ( // [RULE_07]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        c_pump_in[6:0] == 7'b1111101 |=> c_pump_na_out == 21'h0030D4)
        else $error("third PLL pump current wrong");

endmodule : pcb_decode

// >>> pcb_top.sv
// Overview of operation
// (RULE_01) Third PLL filter bits 7:4 each add 100k, 50k, 25k, 12.5k ohm.
// (RULE_02) Third PLL bit 3 applies only the 6k resistor when set.
// (RULE_03) Third PLL feedback bits 10:8 live in offset five bits 2:0.
// (RULE_04) Offset six bit 7 picks divider 3 source: 0 second, 1 third PLL.
// (RULE_05) Offset six bits 6:1: pump weights x8..x1, divisors /24 and /3.
// (RULE_06) Offset six bit 0 picks third PLL base current 10 or 20 uA.
// (RULE_07) Pump current is base times (1+sel) times weight sum over divisor.
// (RULE_08) Offset seven bit 7 enables first PLL reference doubler.
// (RULE_09) Offset seven bit 6 picks first PLL base 10.8 or 21.6 uA.
// (RULE_10) Offset seven bit 5 enables second channel, on after reset.
// (RULE_11) Offset seven bit 4 enables extra loop pole, off after reset.
// (RULE_12) Offset seven bits 3:0 hold divider 5 code, reset 0011.
// (RULE_13) Offset eight bits 7 and 6 enable /1 and /2 reference bypass.
// (RULE_14) Offset eight bits 5:0 hold first PLL reference divider, reset 25.
// (RULE_15) First PLL feedback: low byte offset nine, high bits offset ten.
// (RULE_16) Offset ten bits 7:4 add first PLL resistors, reset 1011.
// (RULE_17) Offset ten bit 3 applies only the 1k resistor when set.
// (RULE_18) Offset eleven: pump weights x32..x1, divisors /24 and /3.
// (RULE_19) All fields read back last written value or reset default.
// (RULE_20) Divider 5 ratio is upper factor times lower factor, 1 to 50.
// (RULE_21) Written bytes are held and committed together at stop.
// (RULE_22) Block bytes go to ascending registers from the host start position.
`timescale 1ns/1ns
module pcb_top (
    input wire logic sys_clk_in, // System clock, 100 MHz
    input wire logic nrst_in, // Sync reset, active low
    input wire logic start_in, // Block transfer begins
    input wire logic [7:0] start_addr_in, // First register position
    input wire logic wr_valid_in, // Write data byte strobe
    input wire logic [7:0] wr_byte_in, // Write data byte
    input wire logic rd_req_in, // Read byte request
    input wire logic stop_in, // Stop condition strobe
    output logic [7:0] rd_byte_out, // Read data byte
    output logic rd_valid_out, // Read data valid pulse
    output logic [3:0] pll_c_res_insert_out, // Third PLL resistors in
    output logic pll_c_res_smallest_only_out, // Third PLL 6k only
    output logic [2:0] pll_c_feedback_count_high_out, // Feedback 10:8
    output logic divider_three_origin_out, // Divider 3 source
    output logic [3:0] pll_c_pump_weights_out, // x8..x1 enables
    output logic pll_c_pump_divisor_large_out, // /24 enable
    output logic pll_c_pump_divisor_small_out, // /3 enable
    output logic pll_c_base_current_select_out, // 20 uA when set
    output logic pll_a_reference_doubler_out, // Reference doubler on
    output logic pll_a_base_current_select_out, // 21.6 uA when set
    output logic pll_a_second_channel_on_out, // Second channel on
    output logic pll_a_extra_pole_on_out, // Extra pole on
    output logic [3:0] divider_five_code_out, // Divider 5 code
    output logic pll_a_ref_bypass_one_out, // Reference /1 path
    output logic pll_a_ref_bypass_two_out, // Reference /2 path
    output logic [5:0] pll_a_reference_count_out, // Reference divider
    output logic [10:0] pll_a_feedback_count_out, // Feedback divider
    output logic [3:0] pll_a_res_insert_out, // First PLL resistors in
    output logic pll_a_res_smallest_only_out, // First PLL 1k only
    output logic [5:0] pll_a_pump_weights_out, // x32..x1 enables
    output logic pll_a_pump_divisor_large_out, // /24 enable
    output logic pll_a_pump_divisor_small_out, // /3 enable
    output logic [5:0] divider_five_ratio_out, // Divider 5 ratio
    output logic [20:0] pll_c_pump_current_out, // Third PLL pump, nA
    output logic [20:0] pll_a_pump_current_out, // First PLL pump, nA
    output logic [10:0] pll_c_loop_res_out, // Third PLL, 100 ohm
    output logic [10:0] pll_a_loop_res_out // First PLL, 100 ohm
);
    import pcb_pkg::*;

    logic [6:0][7:0] regs;
    logic [7:0] ptr;
    logic commit;
    logic [6:0] commit_mask;
    logic [6:0][7:0] commit_data;
    logic [7:0] rd_sel;

    pcb_stage u_stage (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .start_in(start_in),
        .start_addr_in(start_addr_in),
        .wr_valid_in(wr_valid_in),
        .wr_byte_in(wr_byte_in),
        .rd_req_in(rd_req_in),
        .stop_in(stop_in),
        .ptr_out(ptr),
        .commit_out(commit),
        .commit_mask_out(commit_mask),
        .commit_data_out(commit_data)
    );

    // All held bytes land in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            regs <= RST_ALL; // [RULE_19]
        end else if (commit) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (commit_mask[i]) begin
                    regs[i] <= commit_data[i]; // [RULE_21]
                end
            end
        end
    end

    // Positions outside this bank read as zero here
    always_comb begin
        rd_sel = 8'h00;
        if (in_range(ptr)) begin
            rd_sel = regs[reg_index(ptr)]; // [RULE_19]
        end
    end

    // Reads see committed values, never bytes still held
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rd_byte_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_req_in && !start_in;
            if (rd_req_in && !start_in) begin
                rd_byte_out <= rd_sel; // [RULE_19] [RULE_22]
            end
        end
    end

    assign pll_c_res_insert_out =
        regs[IDX_C_FILTER][RES_TOP_POS +: RES_TOP_W]; // [RULE_01]
    assign pll_c_res_smallest_only_out =
        regs[IDX_C_FILTER][RES_ONLY_POS]; // [RULE_02]
    assign pll_c_feedback_count_high_out =
        regs[IDX_C_FILTER][FB_HIGH_POS +: FB_HIGH_W]; // [RULE_03]
    assign divider_three_origin_out =
        regs[IDX_C_PUMP][DIV3_ORIGIN_POS]; // [RULE_04]
    assign pll_c_pump_weights_out =
        regs[IDX_C_PUMP][C_PUMP_WT_POS +: C_PUMP_WT_W]; // [RULE_05]
    assign pll_c_pump_divisor_large_out =
        regs[IDX_C_PUMP][C_PUMP_D24_POS]; // [RULE_05]
    assign pll_c_pump_divisor_small_out =
        regs[IDX_C_PUMP][C_PUMP_D3_POS]; // [RULE_05]
    assign pll_c_base_current_select_out =
        regs[IDX_C_PUMP][C_BASE_SEL_POS]; // [RULE_06]
    assign pll_a_reference_doubler_out =
        regs[IDX_A_CTRL][A_DOUBLER_POS]; // [RULE_08]
    assign pll_a_base_current_select_out =
        regs[IDX_A_CTRL][A_BASE_SEL_POS]; // [RULE_09]
    assign pll_a_second_channel_on_out =
        regs[IDX_A_CTRL][A_CH2_POS]; // [RULE_10]
    assign pll_a_extra_pole_on_out =
        regs[IDX_A_CTRL][A_POLE_POS]; // [RULE_11]
    assign divider_five_code_out =
        regs[IDX_A_CTRL][DIV5_POS +: DIV5_W]; // [RULE_12]
    assign pll_a_ref_bypass_one_out =
        regs[IDX_A_REF][A_BYP1_POS]; // [RULE_13]
    assign pll_a_ref_bypass_two_out =
        regs[IDX_A_REF][A_BYP2_POS]; // [RULE_13]
    assign pll_a_reference_count_out =
        regs[IDX_A_REF][A_REF_POS +: A_REF_W]; // [RULE_14]
    assign pll_a_feedback_count_out = {
        regs[IDX_A_FILTER][FB_HIGH_POS +: FB_HIGH_W],
        regs[IDX_A_FB_LOW]}; // [RULE_15]
    assign pll_a_res_insert_out =
        regs[IDX_A_FILTER][RES_TOP_POS +: RES_TOP_W]; // [RULE_16]
    assign pll_a_res_smallest_only_out =
        regs[IDX_A_FILTER][RES_ONLY_POS]; // [RULE_17]
    assign pll_a_pump_weights_out =
        regs[IDX_A_PUMP][A_PUMP_WT_POS +: A_PUMP_WT_W]; // [RULE_18]
    assign pll_a_pump_divisor_large_out =
        regs[IDX_A_PUMP][A_PUMP_D24_POS]; // [RULE_18]
    assign pll_a_pump_divisor_small_out =
        regs[IDX_A_PUMP][A_PUMP_D3_POS]; // [RULE_18]

    // Derived values trail the registers by one cycle
    pcb_decode u_decode (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .c_filter_in(regs[IDX_C_FILTER]),
        .c_pump_in(regs[IDX_C_PUMP]),
        .a_ctrl_in(regs[IDX_A_CTRL]),
        .a_filter_in(regs[IDX_A_FILTER]),
        .a_pump_in(regs[IDX_A_PUMP]),
        .div5_ratio_out(divider_five_ratio_out),
        .c_pump_na_out(pll_c_pump_current_out),
        .a_pump_na_out(pll_a_pump_current_out),
        .c_res_out(pll_c_loop_res_out),
        .a_res_out(pll_a_loop_res_out)
    );

    sequence read_asked_s;
        rd_req_in && !start_in;
    endsequence

    sequence last_write_s;
        wr_valid_in && !start_in && ptr == OFS_A_PUMP;
    endsequence

    sequence quiet_stop_s;
        !start_in && !wr_valid_in && !rd_req_in ##1 stop_in;
    endsequence

    reset_defaults_a: assert property ( // [RULE_19]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        $past(!nrst_in) |-> regs == RST_ALL
            && pll_a_second_channel_on_out && !pll_a_extra_pole_on_out)
        else $error("reset defaults wrong");

    feedback_default_a: assert property ( // [RULE_15]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        $past(!nrst_in) |-> pll_a_feedback_count_out == 11'h258
            && pll_a_reference_count_out == 6'h19
            && divider_five_code_out == 4'h3)
        else $error("first PLL divider defaults wrong");

    read_back_a: assert property ( // [RULE_19]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        read_asked_s |=> rd_valid_out && rd_byte_out == $past(rd_sel))
        else $error("read byte does not match register");

    regs_stable_a: assert property ( // [RULE_21]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !$past(commit) |-> $stable(regs))
        else $error("register changed before stop");

    write_lands_a: assert property ( // [RULE_21]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        last_write_s ##1 quiet_stop_s |-> ##2
            regs[IDX_A_PUMP] == $past(wr_byte_in, 4))
        else $error("held byte not committed");

    no_spurious_read_a: assert property ( // [RULE_22]
        @(posedge sys_clk_in) disable iff (!nrst_in)
        rd_valid_out |-> $past(rd_req_in))
        else $error("read valid without request");

endmodule : pcb_top

// >>> pcb_host_model.sv
`timescale 1ns/1ns
module pcb_host_model (
    input wire logic sys_clk_in, // System clock
    output logic start_out, // Block start
    output logic [7:0] addr_out, // First position
    output logic wr_out, // Write strobe
    output logic [7:0] byte_out, // Write byte
    output logic rd_out, // Read request
    output logic stop_out // Stop strobe
);
    initial begin
        {start_out, wr_out, rd_out, stop_out, addr_out, byte_out} = 20'h0;
    end
    // Kind bits: start, write, read, stop; one request per edge
    task automatic step(input logic [3:0] k, input logic [7:0] v);
        @(posedge sys_clk_in);
        {start_out, wr_out, rd_out, stop_out} <= k;
        // Released lines show inverted data, never a stale copy
        addr_out <= k[3] ? v : ~addr_out;
        byte_out <= k[2] ? v : ~byte_out;
    endtask : step
endmodule : pcb_host_model

// >>> tb_pcb_top.sv
`timescale 1ns/1ns
module tb_pcb_top;
    import pcb_pkg::*;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    wire hs, hw, hr, hp, rd_valid_out;
    wire [7:0] ha, hb, rd_byte_out;
    wire [6:0][7:0] f;
    wire [69:0] d;
    logic [6:0][7:0] regs, nxt;
    // Corner codes that random bytes seldom reach; leftmost byte is offset 0B
    localparam logic [6:0][7:0] DIRECTED = {8'hFD, 8'hF4, 8'hFF, 8'hC3,
        8'hDF, 8'h7D, 8'h9D};
    logic [7:0] q[$];
    logic [31:0] seed = 32'h12D2;
    int errors = 0;
    int n_compared = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    pcb_host_model host_u (.sys_clk_in(sys_clk_in), .start_out(hs),
        .addr_out(ha), .wr_out(hw), .byte_out(hb), .rd_out(hr),
        .stop_out(hp));
    pcb_top dut_u (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .start_in(hs), .start_addr_in(ha), .wr_valid_in(hw),
        .wr_byte_in(hb), .rd_req_in(hr), .stop_in(hp),
        .rd_byte_out(rd_byte_out), .rd_valid_out(rd_valid_out),
        .pll_c_res_insert_out(f[0][7:4]),
        .pll_c_res_smallest_only_out(f[0][3]),
        .pll_c_feedback_count_high_out(f[0][2:0]),
        .divider_three_origin_out(f[1][7]),
        .pll_c_pump_weights_out(f[1][6:3]),
        .pll_c_pump_divisor_large_out(f[1][2]),
        .pll_c_pump_divisor_small_out(f[1][1]),
        .pll_c_base_current_select_out(f[1][0]),
        .pll_a_reference_doubler_out(f[2][7]),
        .pll_a_base_current_select_out(f[2][6]),
        .pll_a_second_channel_on_out(f[2][5]),
        .pll_a_extra_pole_on_out(f[2][4]), .divider_five_code_out(f[2][3:0]),
        .pll_a_ref_bypass_one_out(f[3][7]), .pll_a_ref_bypass_two_out(f[3][6]),
        .pll_a_reference_count_out(f[3][5:0]),
        .pll_a_feedback_count_out({f[5][2:0], f[4]}),
        .pll_a_res_insert_out(f[5][7:4]),
        .pll_a_res_smallest_only_out(f[5][3]),
        .pll_a_pump_weights_out(f[6][7:2]),
        .pll_a_pump_divisor_large_out(f[6][1]),
        .pll_a_pump_divisor_small_out(f[6][0]),
        .divider_five_ratio_out(d[69:64]), .pll_c_pump_current_out(d[63:43]),
        .pll_a_pump_current_out(d[42:22]), .pll_c_loop_res_out(d[21:11]),
        .pll_a_loop_res_out(d[10:0]));
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic logic [20:0] pump(int b, bit s, int w, bit l, bit m);
        int dv = 24 * l + 3 * m;
        return (dv == 0) ? 21'h0 : 21'(b * (1 + s) * w / dv);
    endfunction : pump
    function automatic logic [10:0] res(logic [3:0] n, bit o, int u);
        return 11'(o ? u : 1000 * n[3] + 500 * n[2] + 250 * n[1] + 125 * n[0]);
    endfunction : res
    function automatic logic [69:0] derive(logic [6:0][7:0] r);
        int hi[4] = '{1, 2, 4, 5};
        int lo[4] = '{1, 3, 5, 10};
        return {6'(hi[r[2][3:2]] * lo[r[2][1:0]]),
            pump(10000, r[1][0], r[1][6:3], r[1][2], r[1][1]),
            pump(10800, r[2][6], r[6][7:2], r[6][1], r[6][0]),
            res(r[0][7:4], r[0][3], 60), res(r[5][7:4], r[5][3], 10)};
    endfunction : derive
    task automatic check(input logic [69:0] got, input logic [69:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Positions outside the bank read as zero
    task automatic rd_blk(input logic [7:0] a, input int n);
        host_u.step(4'h8, a);
        for (int i = 0; i < n; i++) begin
            q.push_back((a >= 8'h05 && a <= 8'h0B) ? regs[a - 8'h05] : 8'h00);
            a++;
            host_u.step(4'h2, 8'h00);
        end
        host_u.step(4'h1, 8'h00);
    endtask : rd_blk
    task automatic settle();
        repeat (5) host_u.step(4'h0, 8'h00);
        @(negedge sys_clk_in);
        check(70'(f), 70'(regs));
        check(d, derive(regs));
    endtask : settle
    always @(negedge sys_clk_in) begin
        if (rd_valid_out === 1'b1) begin
            check(70'(rd_byte_out), 70'(q.pop_front()));
        end
    end
    initial begin
        #100000;
        errors++;
        finish_test();
    end
    initial begin
        regs = RST_ALL;
        repeat (8) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        settle();
        rd_blk(8'h04, 9);
        for (int t = 0; t < 6; t++) begin
            host_u.step(4'h8, 8'h05);
            // Eighth byte lands past the bank and is dropped
            for (int i = 0; i < 8; i++) begin
                seed = xs(seed);
                host_u.step(4'h4, seed[7:0]);
                if (i < 7) begin
                    nxt[i] = seed[7:0];
                end
            end
            rd_blk(8'h05, 7);
            regs = nxt;
            settle();
            rd_blk(8'h05, 7);
        end
        host_u.step(4'h8, 8'h05);
        for (int i = 0; i < 7; i++) begin
            host_u.step(4'h4, DIRECTED[i]);
        end
        // Quiet cycle before stop, as write_lands_a expects; all seven held bytes commit together
        host_u.step(4'h0, 8'h00);
        host_u.step(4'h1, 8'h00);
        regs = DIRECTED;
        settle();
        rd_blk(8'h05, 7);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        regs = RST_ALL;
        settle();
        settle();
        check(70'(q.size()), 70'h0);
        finish_test();
    end
endmodule : tb_pcb_top
